// file: design/vpg_vbus_path_gpio_loader.sv
// Function
// - source path disable copies source_off_level into the selected pin output.
// - sink path enable copies sink_on_level into the selected pin output.
// - sink path disable copies sink_off_level into the selected pin output.
// - every load sets drive enable, leaves push-pull select alone.
// - loaded values show in the pin's control register on host reads.
// - source levels have no effect while source select is gate driver code.
// - sink levels have no effect while sink select is gate driver code.
// - pump register bit 1 enables source gate charge pump, resets zero.
// - reserved bits read zero and ignore writes.
// - select 000 is gate driver, 001 to 100 pins one to four.
// - enabled pin drives low for zero, high or floats for one.
`timescale 1ns/1ns
`default_nettype none
module vpg_vbus_path_gpio_loader #(
  parameter int NUM_PINS = 4
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [7:0] regAddr,
  input wire logic regWr,
  input wire logic [7:0] regWdata,
  input wire logic regRd,
  output logic [7:0] regRdata,
  input wire logic [2:0] sourcePathPinSelect,
  input wire logic [2:0] sinkPathPinSelect,
  input wire vpg_pkg::vpg_events_t pathEvents,
  input wire logic [NUM_PINS-1:0] pinIn,
  output logic [NUM_PINS-1:0] pinOut,
  output logic [NUM_PINS-1:0] pinOe_n,
  output logic sourcePumpEnable
);

  function automatic logic [NUM_PINS-1:0] selDecode(input logic [2:0] sel);
    logic [NUM_PINS-1:0] hit;
    hit = '0;
    for (int i = 0; i < NUM_PINS; i++) begin
      if (sel == 3'(i + 1) && sel <= vpg_pkg::SEL_LAST) begin
        hit[i] = 1'b1;
      end
    end
    return hit;
  endfunction : selDecode

  logic [7:0] levels_q;
  logic [7:0] pump_q;
  vpg_pkg::vpg_pin_t [NUM_PINS-1:0] pins_q;
  logic [NUM_PINS-1:0] pinSync1_q;
  logic [NUM_PINS-1:0] pinSync2_q;
  logic [NUM_PINS-1:0] srcHit;
  logic [NUM_PINS-1:0] snkHit;
  logic [NUM_PINS-1:0] pinWr;
  logic srcLevel;
  logic snkLevel;

  // off wins over on in the same cycle: a fault must never leave a gate on
  assign srcLevel = pathEvents.srcOff ? levels_q[vpg_pkg::LVL_SRC_OFF]
                                      : levels_q[vpg_pkg::LVL_SRC_ON];
  assign snkLevel = pathEvents.snkOff ? levels_q[vpg_pkg::LVL_SNK_OFF]
                                      : levels_q[vpg_pkg::LVL_SNK_ON];
  // gate driver code decodes to no pin, so nothing loads
  assign srcHit = (pathEvents.srcOn || pathEvents.srcOff) ?
                  selDecode(sourcePathPinSelect) : '0;
  assign snkHit = (pathEvents.snkOn || pathEvents.snkOff) ?
                  selDecode(sinkPathPinSelect) : '0;

  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      pinWr[i] = regWr && regAddr == vpg_pkg::PIN_CTRL_BASE + 8'(i);
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      levels_q <= vpg_pkg::LEVELS_RESET;
    end else if (regWr && regAddr == vpg_pkg::LEVELS_ADDR) begin
      levels_q <= regWdata & vpg_pkg::LEVELS_MASK;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      pump_q <= vpg_pkg::PUMP_RESET;
    end else if (regWr && regAddr == vpg_pkg::PUMP_ADDR) begin
      pump_q <= regWdata & vpg_pkg::PUMP_MASK;
    end
  end

  // source load beats sink load if both name one pin
  always_ff @(posedge clock) begin
    if (!nrst) begin
      pins_q <= {NUM_PINS{vpg_pkg::PIN_RESET}};
    end else begin
      for (int i = 0; i < NUM_PINS; i++) begin
        if (srcHit[i]) begin
          pins_q[i].outVal <= srcLevel;
          pins_q[i].driveEn <= 1'b1;
        end else if (snkHit[i]) begin
          pins_q[i].outVal <= snkLevel;
          pins_q[i].driveEn <= 1'b1;
        end else if (pinWr[i]) begin
          pins_q[i].outVal <= regWdata[vpg_pkg::PIN_O];
          pins_q[i].driveEn <= regWdata[vpg_pkg::PIN_OE];
        end
        if (pinWr[i]) begin
          pins_q[i].pushPull <= regWdata[vpg_pkg::PIN_PP];
          pins_q[i].inEn <= regWdata[vpg_pkg::PIN_IE];
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      pinSync1_q <= '0;
      pinSync2_q <= '0;
    end else begin
      pinSync1_q <= pinIn;
      pinSync2_q <= pinSync1_q;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      pinOut <= '0;
      pinOe_n <= '1;
    end else begin
      for (int i = 0; i < NUM_PINS; i++) begin
        pinOut[i] <= pins_q[i].outVal;
        pinOe_n[i] <= !(pins_q[i].driveEn &&
                        (!pins_q[i].outVal || pins_q[i].pushPull));
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      sourcePumpEnable <= 1'b0;
    end else begin
      sourcePumpEnable <= pump_q[vpg_pkg::PUMP_EN_BIT];
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      regRdata <= 8'h00;
    end else if (regRd) begin
      regRdata <= 8'h00;
      if (regAddr == vpg_pkg::LEVELS_ADDR) begin
        regRdata <= levels_q;
      end else if (regAddr == vpg_pkg::PUMP_ADDR) begin
        regRdata <= pump_q;
      end
      for (int i = 0; i < NUM_PINS; i++) begin
        if (regAddr == vpg_pkg::PIN_CTRL_BASE + 8'(i)) begin
          regRdata <= {3'h0, pins_q[i].inEn, pins_q[i].pushPull,
                       pins_q[i].driveEn, pins_q[i].outVal,
                       pins_q[i].inEn & pinSync2_q[i]};
        end
      end
    end
  end

  // helper vectors for the checks below
  logic [NUM_PINS-1:0] outVec;
  logic [NUM_PINS-1:0] oeVec;
  logic [NUM_PINS-1:0] ppVec;
  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      outVec[i] = pins_q[i].outVal;
      oeVec[i] = pins_q[i].driveEn;
      ppVec[i] = pins_q[i].pushPull;
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);

  property p_srcOn;
    pathEvents.srcOn && !pathEvents.srcOff && srcHit != '0 |=>
      (outVec & $past(srcHit)) ==
      ($past(srcHit) & {NUM_PINS{$past(levels_q[vpg_pkg::LVL_SRC_ON])}});
  endproperty
  a_srcOn: assert property (p_srcOn)
    else $error("source on level not loaded");

  property p_srcOff;
    pathEvents.srcOff && srcHit != '0 |=>
      (outVec & $past(srcHit)) ==
      ($past(srcHit) & {NUM_PINS{$past(levels_q[vpg_pkg::LVL_SRC_OFF])}});
  endproperty
  a_srcOff: assert property (p_srcOff)
    else $error("source off level not loaded");

  property p_snkOn;
    pathEvents.snkOn && !pathEvents.snkOff && (snkHit & ~srcHit) != '0 |=>
      (outVec & $past(snkHit & ~srcHit)) == ($past(snkHit & ~srcHit) &
      {NUM_PINS{$past(levels_q[vpg_pkg::LVL_SNK_ON])}});
  endproperty
  a_snkOn: assert property (p_snkOn)
    else $error("sink on level not loaded");

  property p_snkOff;
    pathEvents.snkOff && (snkHit & ~srcHit) != '0 |=>
      (outVec & $past(snkHit & ~srcHit)) == ($past(snkHit & ~srcHit) &
      {NUM_PINS{$past(levels_q[vpg_pkg::LVL_SNK_OFF])}});
  endproperty
  a_snkOff: assert property (p_snkOff)
    else $error("sink off level not loaded");

  // a host write in the load cycle still sets push-pull, so skip those pins
  property p_loadDrive;
    (srcHit | snkHit) != '0 |=>
      (oeVec & $past(srcHit | snkHit)) == $past(srcHit | snkHit) &&
      (ppVec & $past((srcHit | snkHit) & ~pinWr)) ==
      ($past(ppVec) & $past((srcHit | snkHit) & ~pinWr));
  endproperty
  a_loadDrive: assert property (p_loadDrive)
    else $error("load did not enable drive or touched push-pull");

  sequence s_loadThenRead;
    srcHit[0] && !pinWr[0] ##1 regRd && regAddr == vpg_pkg::PIN_CTRL_BASE;
  endsequence
  property p_readBack;
    s_loadThenRead |=> regRdata[vpg_pkg::PIN_OE] &&
      regRdata[vpg_pkg::PIN_O] == $past(srcLevel, 2);
  endproperty
  a_readBack: assert property (p_readBack)
    else $error("pin register does not show loaded value");

  property p_srcGate;
    sourcePathPinSelect == vpg_pkg::SEL_GATE && !regWr &&
      (snkHit == '0) |=> $stable(pins_q);
  endproperty
  a_srcGate: assert property (p_srcGate)
    else $error("source event changed a pin under gate select");

  property p_snkGate;
    sinkPathPinSelect == vpg_pkg::SEL_GATE && !regWr &&
      (srcHit == '0) |=> $stable(pins_q);
  endproperty
  a_snkGate: assert property (p_snkGate)
    else $error("sink event changed a pin under gate select");

  property p_pump;
    regWr && regAddr == vpg_pkg::PUMP_ADDR |=>
      ##1 sourcePumpEnable == $past(regWdata[vpg_pkg::PUMP_EN_BIT], 2);
  endproperty
  a_pump: assert property (p_pump)
    else $error("pump enable does not follow register");

  property p_reserved;
    regRd |=> (regRdata & ~vpg_pkg::LEVELS_MASK) == 8'h00 ||
      $past(regAddr) != vpg_pkg::LEVELS_ADDR;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved bits read nonzero");

  property p_drive;
    ##1 pinOe_n[0] == !($past(oeVec[0]) &&
      (!$past(outVec[0]) || $past(ppVec[0])));
  endproperty
  a_drive: assert property (p_drive)
    else $error("pin drive enable wrong");

endmodule : vpg_vbus_path_gpio_loader
`default_nettype wire

// file: design/vpg_pkg.sv
package vpg_pkg;

  // register map
  localparam logic [7:0] PIN_CTRL_BASE = 8'h82;
  localparam logic [7:0] LEVELS_ADDR = 8'h87;
  localparam logic [7:0] PUMP_ADDR = 8'h88;

  // path_pin_levels field positions and writable mask
  localparam int LVL_SRC_ON = 5;
  localparam int LVL_SRC_OFF = 4;
  localparam int LVL_SNK_ON = 1;
  localparam int LVL_SNK_OFF = 0;
  localparam logic [7:0] LEVELS_MASK = 8'h33;
  localparam logic [7:0] LEVELS_RESET = 8'h00;

  // source_pump_control field position and writable mask
  localparam int PUMP_EN_BIT = 1;
  localparam logic [7:0] PUMP_MASK = 8'h02;
  localparam logic [7:0] PUMP_RESET = 8'h00;

  // pin_control_register field positions
  localparam int PIN_IE = 4;
  localparam int PIN_PP = 3;
  localparam int PIN_OE = 2;
  localparam int PIN_O = 1;
  localparam int PIN_I = 0;

  // path select codes
  localparam logic [2:0] SEL_GATE = 3'h0;
  localparam logic [2:0] SEL_LAST = 3'h4;

  typedef struct packed {
    logic inEn;
    logic pushPull;
    logic driveEn;
    logic outVal;
  } vpg_pin_t;

  localparam vpg_pin_t PIN_RESET = '{1'b0, 1'b0, 1'b0, 1'b0};

  // one strobe per path event
  typedef struct packed {
    logic srcOn;
    logic srcOff;
    logic snkOn;
    logic snkOff;
  } vpg_events_t;

endpackage : vpg_pkg

// file: bench/vpg_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module vpg_host_model (
  input wire logic clock,
  input wire logic [7:0] regRdata,
  output logic [7:0] regAddr,
  output logic regWr,
  output logic [7:0] regWdata,
  output logic regRd
);
  initial begin
    regAddr = 8'h00;
    regWr = 1'b0;
    regWdata = 8'h00;
    regRd = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    regAddr = a;
    regWdata = d;
    regWr = 1'b1;
    @(negedge clock);
    regWr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clock);
    regAddr = a;
    regRd = 1'b1;
    @(negedge clock);
    regRd = 1'b0;
    @(negedge clock);
    d = regRdata;
  endtask : rd
  // pump goes first: it needs tens of ms before the source gate
  task automatic pump(input logic on);
    wr(8'h88, {6'h00, on, 1'b0});
  endtask : pump
endmodule : vpg_host_model
`default_nettype wire

// file: bench/vbus_path_gpio_loader_tb.sv
`timescale 1ns/1ns
`default_nettype none
module vbus_path_gpio_loader_tb;
  localparam vpg_pkg::vpg_events_t SON = 4'h8;
  localparam vpg_pkg::vpg_events_t SOFF = 4'h4;
  localparam vpg_pkg::vpg_events_t KON = 4'h2;
  localparam vpg_pkg::vpg_events_t KOFF = 4'h1;
  localparam logic [7:0] LVL = vpg_pkg::LEVELS_ADDR;
  localparam logic [7:0] PBASE = vpg_pkg::PIN_CTRL_BASE;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] regAddr, regWdata, regRdata, rdata;
  logic regWr, regRd, sourcePumpEnable;
  logic [2:0] srcSel = 3'h0;
  logic [2:0] snkSel = 3'h0;
  vpg_pkg::vpg_events_t ev = '0;
  logic [3:0] pinOut, pinOe_n;
  wire logic [3:0] pinWire;
  int errors = 0;
  int checks_done = 0;
  // released pins sit on a pull-up
  assign pinWire = pinOe_n | pinOut;
  always #5 clock = ~clock;
  vpg_host_model i_host (.clock(clock), .regRdata(regRdata),
    .regAddr(regAddr), .regWr(regWr), .regWdata(regWdata), .regRd(regRd));
  vpg_vbus_path_gpio_loader i_dut (.clock(clock), .nrst(nrst),
    .regAddr(regAddr), .regWr(regWr), .regWdata(regWdata), .regRd(regRd),
    .regRdata(regRdata), .sourcePathPinSelect(srcSel),
    .sinkPathPinSelect(snkSel), .pathEvents(ev), .pinIn(pinWire),
    .pinOut(pinOut), .pinOe_n(pinOe_n),
    .sourcePumpEnable(sourcePumpEnable));
  task automatic chk(input string n, input logic [7:0] e,
    input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic pulse(input vpg_pkg::vpg_events_t e);
    @(negedge clock);
    ev = e;
    @(negedge clock);
    ev = '0;
  endtask : pulse
  // extra cycles let the pin echo through the input synchroniser
  task automatic pin(input int i, input logic [7:0] r);
    repeat (3) @(negedge clock);
    i_host.rd(PBASE + i[7:0], rdata);
    chk("pin reg", r, rdata);
    chk("pin drive", {6'h00, ~r[2] | (r[1] & ~r[3]), r[1]},
      {6'h00, pinOe_n[i], pinOut[i]});
  endtask : pin
  task automatic t_reset();
    for (int a = 8'h82; a <= 8'h89; a++) begin
      i_host.rd(a[7:0], rdata);
      chk("reset read", 8'h00, rdata);
    end
    chk("reset outs", 8'h0f, {sourcePumpEnable, 3'h0, pinOe_n});
  endtask : t_reset
  task automatic t_regs();
    i_host.wr(LVL, 8'hff);
    i_host.rd(LVL, rdata);
    chk("levels", 8'h33, rdata);
    i_host.wr(vpg_pkg::PUMP_ADDR, 8'hff);
    i_host.rd(vpg_pkg::PUMP_ADDR, rdata);
    chk("pump", 8'h02, rdata);
    chk("pump on", 8'h01, {7'h00, sourcePumpEnable});
    i_host.pump(1'b0);
    repeat (2) @(negedge clock);
    chk("pump off", 8'h00, {7'h00, sourcePumpEnable});
  endtask : t_regs
  task automatic t_loads();
    i_host.wr(LVL, 8'h21);
    for (int i = 0; i < 4; i++) begin
      i_host.wr(PBASE + i[7:0], 8'h08);
      srcSel = 3'(i + 1);
      pulse(SON);
      pin(i, 8'h0e);
      pulse(SOFF);
      pin(i, 8'h0c);
      srcSel = 3'h0;
      snkSel = 3'(i + 1);
      pulse(KON);
      pin(i, 8'h0c);
      pulse(KOFF);
      pin(i, 8'h0e);
      snkSel = 3'h0;
    end
  endtask : t_loads
  task automatic t_ignore();
    logic [2:0] codes [3] = '{3'h0, 3'h5, 3'h7};
    i_host.wr(LVL, 8'h00);
    foreach (codes[k]) begin
      srcSel = codes[k];
      snkSel = codes[k];
      pulse(4'hf);
      for (int i = 0; i < 4; i++) pin(i, 8'h0e);
    end
    srcSel = 3'h1;
    snkSel = 3'h0;
  endtask : t_ignore
  task automatic t_od();
    i_host.wr(PBASE, 8'h10);
    i_host.wr(LVL, 8'h20);
    pulse(SON);
    pin(0, 8'h17);
    pulse(SOFF);
    pin(0, 8'h14);
  endtask : t_od
  task automatic t_race();
    fork
      i_host.wr(PBASE, 8'h08);
      pulse(SON);
    join
    pin(0, 8'h0e);
    // read in the cycle right after the strobe must already see the load
    fork
      pulse(SOFF);
      begin
        @(negedge clock);
        i_host.rd(PBASE, rdata);
      end
    join
    chk("pin quick", 8'h0c, rdata);
  endtask : t_race
  task automatic summarize();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : summarize
  initial begin
    repeat (12) @(negedge clock);
    nrst = 1'b1;
    t_reset();
    t_regs();
    t_loads();
    t_ignore();
    t_od();
    t_race();
    summarize();
  end
  initial begin
    #50000;
    errors++;
    summarize();
  end
endmodule : vbus_path_gpio_loader_tb
`default_nettype wire
